// ### astm_pkg.sv
package astm_pkg;
   // Clock and timing
   localparam int CLK_HZ = 100_000_000;
   localparam int POR_TIME_MS = 4;
   localparam int POR_CYCLES = POR_TIME_MS * (CLK_HZ / 1000);
   localparam int PROBE_TIME_US = 12;
   localparam int PROBE_CYCLES = PROBE_TIME_US * (CLK_HZ / 1_000_000);
   // Probe delay with an external oscillator, in tenths of its period
   localparam int EXT_OSC_PERIODS_X10 = 36;
   localparam int EXT_OSC_HZ = 307_200;
   localparam int INT_SCK_HALF_CYCLES = 50;
   localparam int TMR_W = 20;
   // Word layout
   localparam int WORD_BITS = 32;
   localparam int RESULT_BITS = WORD_BITS - 1;
   localparam int IN_BITS = 16;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] LAST_EDGE = 6'h1f;
   localparam logic [CNT_W-1:0] CHAN_FALLS = 6'h08;
   localparam logic [CNT_W-1:0] CFG_FALLS = 6'h10;
   // Reset values
   localparam logic [7:0] CHAN_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;

   typedef enum logic [2:0] {ST_POR, ST_CONV, ST_SLEEP, ST_WAIT, ST_DATA} astm_state_t;
   typedef enum logic [1:0] {MD_EXT, MD_INT_SINGLE, MD_INT_CONT} astm_mode_t;

   typedef struct packed {
      logic [7:0] chan;
      logic [7:0] cfg;
   } astm_sel_t;

   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic sck_pullup;
      logic sdo_out;
      logic sdo_oe;
   } astm_pins_t;
endpackage

// ### astm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module astm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_bad_width
      $error("astm_sync needs at least one bit");
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ### astm_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module astm_serial_port #(
   parameter int POR_CYCLES_P = astm_pkg::POR_CYCLES,
   parameter int EXT_OSC_HZ_P = astm_pkg::EXT_OSC_HZ,
   parameter int SCK_HALF_P = astm_pkg::INT_SCK_HALF_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial pins
   input wire logic cs_n,
   input wire logic sck_in,
   input wire logic sdi,
   input wire logic ext_osc_sel,
   output var astm_pkg::astm_pins_t pins,
   // Converter core
   input wire logic conv_done,
   input wire logic [astm_pkg::RESULT_BITS-1:0] conv_result,
   output var logic conv_start,
   output var logic converting,
   output var astm_pkg::astm_sel_t sel
);
   import astm_pkg::*;

   localparam int EXT_PROBE = (CLK_HZ / 10) * EXT_OSC_PERIODS_X10 / EXT_OSC_HZ_P;
   localparam logic [TMR_W-1:0] POR_LOAD = TMR_W'(POR_CYCLES_P - 1);
   localparam logic [TMR_W-1:0] HALF_LOAD = TMR_W'(SCK_HALF_P - 1);
   localparam logic [TMR_W-1:0] PROBE_INT_LOAD = TMR_W'(PROBE_CYCLES - 1);
   localparam logic [TMR_W-1:0] PROBE_EXT_LOAD = TMR_W'(EXT_PROBE - 1);
   localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

   if (SCK_HALF_P < 2 || EXT_PROBE < 1 || POR_CYCLES_P < 2 || POR_CYCLES_P >= 2 ** TMR_W) begin : g_bad_param
      $error("astm_serial_port parameters out of range");
   end

   logic [3:0] sync_q;
   logic cs_s, sck_s, sdi_s, osc_s;
   logic cs_q, sck_q, sck_drv, next_sck_drv;
   astm_state_t state, next_state;
   astm_mode_t mode, next_mode;
   astm_mode_t cs_mode_pick;
   logic [TMR_W-1:0] tmr, next_tmr;
   logic [CNT_W-1:0] rise_cnt, fall_cnt;
   logic [WORD_BITS-1:0] out_sr;
   logic [IN_BITS-1:0] in_word;

   astm_sync #(.W(4)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .d({cs_n, sck_in, sdi, ext_osc_sel}),
      .q(sync_q)
   );
   assign {cs_s, sck_s, sdi_s, osc_s} = sync_q;

   // Edge and event decode
   wire tmr_done = (tmr == '0);
   wire int_mode = (mode != MD_EXT);
   wire io_state = (state == ST_SLEEP) || (state == ST_DATA);
   wire cs_rise = cs_s & ~cs_q;
   wire cs_fall = ~cs_s & cs_q;
   wire ext_rise = (mode == MD_EXT) & io_state & ~cs_s & sck_s & ~sck_q;
   wire ext_fall = (mode == MD_EXT) & (state == ST_DATA) & ~cs_s & ~sck_s & sck_q;
   wire int_rise = int_mode & tmr_done & ((state == ST_WAIT) | ((state == ST_DATA) & ~sck_drv));
   wire int_fall = int_mode & tmr_done & (state == ST_DATA) & sck_drv;
   wire rise_ev = ext_rise | int_rise;
   wire fall_ev = ext_fall | int_fall;
   wire ext_word_end = (mode == MD_EXT) & fall_ev & (fall_cnt == LAST_EDGE);
   wire int_word_end = int_mode & rise_ev & (rise_cnt == LAST_EDGE);
   wire aborted = (state == ST_DATA) & cs_rise & (mode != MD_INT_CONT);
   wire por_end = (state == ST_POR) & tmr_done;
   wire data_end = (state == ST_DATA) & (ext_word_end | int_word_end | aborted);
   wire start_conv = por_end | data_end;
   wire take_chan = data_end & (fall_cnt >= CHAN_FALLS);
   wire take_cfg = data_end & (fall_cnt >= CFG_FALLS);
   wire [TMR_W-1:0] probe_load = osc_s ? PROBE_EXT_LOAD : PROBE_INT_LOAD;
   assign cs_mode_pick = sck_s ? MD_INT_SINGLE : MD_EXT;

   always_comb begin
      next_state = state;
      next_mode = mode;
      next_tmr = tmr_done ? tmr : tmr - TMR_ONE;
      next_sck_drv = sck_drv;
      case (state)
         ST_POR: begin
            if (tmr_done) begin
               next_mode = sck_s ? (cs_s ? MD_INT_SINGLE : MD_INT_CONT) : MD_EXT;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               next_sck_drv = 1'b0;
               if (mode == MD_INT_CONT) begin
                  next_state = ST_WAIT;
                  next_tmr = HALF_LOAD;
               end else if ((mode == MD_INT_SINGLE) && !cs_s) begin
                  next_state = ST_WAIT;
                  next_tmr = probe_load;
               end else begin
                  next_state = ST_SLEEP;
               end
            end
         end
         ST_SLEEP: begin
            if ((mode == MD_INT_SINGLE) && !cs_s && !cs_fall) begin
               next_state = ST_WAIT;
               next_tmr = probe_load;
            end else if (rise_ev) begin
               next_state = ST_DATA;
            end
         end
         ST_WAIT: begin
            if ((mode == MD_INT_SINGLE) && cs_s) begin
               next_state = ST_SLEEP;
            end else if (rise_ev) begin
               next_state = ST_DATA;
               next_sck_drv = 1'b1;
               next_tmr = HALF_LOAD;
            end
         end
         ST_DATA: begin
            if (int_rise | int_fall) begin
               next_sck_drv = int_rise;
               next_tmr = HALF_LOAD;
            end
         end
         default: begin
            next_state = ST_POR;
         end
      endcase
      if (cs_fall && (state != ST_POR) && (state != ST_DATA)) begin
         next_mode = cs_mode_pick;
      end
      if (start_conv) begin
         next_state = ST_CONV;
         next_sck_drv = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= ST_POR;
         mode <= MD_EXT;
         tmr <= POR_LOAD;
         sck_drv <= 1'b0;
         cs_q <= 1'b1;
         sck_q <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         tmr <= next_tmr;
         sck_drv <= next_sck_drv;
         cs_q <= cs_s;
         sck_q <= sck_s;
      end
   end

   // Edge counters, cleared when a conversion starts
   always_ff @(posedge ref_clk) begin
      if (reset || start_conv) begin
         rise_cnt <= '0;
         fall_cnt <= '0;
      end else begin
         if (rise_ev) begin
            rise_cnt <= rise_cnt + CNT_ONE;
         end
         if (fall_ev) begin
            fall_cnt <= fall_cnt + CNT_ONE;
         end
      end
   end

   // Input word, first bit on the first rise
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         in_word <= '0;
      end else if (rise_ev && (rise_cnt < CNT_W'(IN_BITS))) begin
         in_word[IN_BITS - 1 - int'(rise_cnt)] <= sdi_s;
      end
   end

   // Output word: leading zero is the done flag, then the result
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_sr <= '0;
      end else if ((state == ST_CONV) && conv_done) begin
         out_sr <= {1'b0, conv_result};
      end else if (fall_ev) begin
         out_sr <= {out_sr[WORD_BITS-2:0], 1'b0};
      end
   end

   // Settings take effect with the conversion they start
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sel <= '{chan: CHAN_RESET, cfg: CFG_RESET};
      end else begin
         if (take_chan) begin
            sel.chan <= in_word[IN_BITS-1 -: 8];
         end
         if (take_cfg) begin
            sel.cfg <= in_word[7:0];
         end
      end
   end

   // Registered pins and core strobes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pins <= '{sck_out: 1'b0, sck_oe: 1'b0, sck_pullup: 1'b1, sdo_out: 1'b0, sdo_oe: 1'b0};
         conv_start <= 1'b0;
         converting <= 1'b0;
      end else begin
         pins.sck_out <= sck_drv;
         pins.sck_oe <= int_mode && !cs_s && (state != ST_POR);
         pins.sck_pullup <= (state == ST_POR) || cs_s;
         pins.sdo_out <= (state == ST_CONV) || out_sr[WORD_BITS-1];
         pins.sdo_oe <= !cs_s && (state != ST_POR);
         conv_start <= start_conv;
         converting <= (state == ST_CONV);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_last_ext_fall;
      (mode == MD_EXT) && (state == ST_DATA) && fall_ev && (fall_cnt == LAST_EDGE);
   endsequence
   sequence s_last_int_rise;
      int_mode && (state == ST_DATA) && rise_ev && (rise_cnt == LAST_EDGE);
   endsequence
   sequence s_conv_pins;
      conv_start && (state == ST_CONV) ##1 (pins.sdo_out && pins.sck_out);
   endsequence

   property p_ext_word_end;
      s_last_ext_fall |=> s_conv_pins;
   endproperty
   a_ext_word_end: assert property (p_ext_word_end) else $error("no conversion after 32nd fall");

   property p_int_word_end;
      s_last_int_rise |=> s_conv_pins;
   endproperty
   a_int_word_end: assert property (p_int_word_end) else $error("no conversion after 32nd rise");

   property p_sdo_off;
      cs_s && (state != ST_POR) |=> !pins.sdo_oe;
   endproperty
   a_sdo_off: assert property (p_sdo_off) else $error("data out driven while deselected");

   property p_ext_flag;
      (mode == MD_EXT) && !cs_s && (state == ST_CONV) |=> pins.sdo_oe && pins.sdo_out;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("busy flag missing");

   property p_load_result;
      (state == ST_CONV) && conv_done |=> out_sr == {1'b0, $past(conv_result)};
   endproperty
   a_load_result: assert property (p_load_result) else $error("result not loaded");

   property p_abort;
      aborted |=> conv_start && (state == ST_CONV);
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not start conversion");

   property p_keep_chan;
      data_end && (fall_cnt < CHAN_FALLS) |=> sel == $past(sel);
   endproperty
   a_keep_chan: assert property (p_keep_chan) else $error("early abort changed settings");

   property p_chan_only;
      data_end && (fall_cnt >= CHAN_FALLS) && (fall_cnt < CFG_FALLS)
         |=> (sel.chan == $past(in_word[15:8])) && (sel.cfg == $past(sel.cfg));
   endproperty
   a_chan_only: assert property (p_chan_only) else $error("channel-only update wrong");

   property p_both;
      data_end && (fall_cnt >= CFG_FALLS) |=> sel == $past(in_word);
   endproperty
   a_both: assert property (p_both) else $error("full update wrong");

   property p_probe;
      (state == ST_SLEEP) && (mode == MD_INT_SINGLE) && !cs_s && !cs_fall && !osc_s
         |=> (state == ST_WAIT) && (tmr == PROBE_INT_LOAD);
   endproperty
   a_probe: assert property (p_probe) else $error("probe delay not loaded");

   property p_cont_sleep;
      (mode == MD_INT_CONT) && (state == ST_CONV) && conv_done |=> (state == ST_WAIT) && (tmr == HALF_LOAD);
   endproperty
   a_cont_sleep: assert property (p_cont_sleep) else $error("continuous sleep wrong");

   property p_ext_no_drive;
      mode == MD_EXT |=> !pins.sck_oe;
   endproperty
   a_ext_no_drive: assert property (p_ext_no_drive) else $error("clock driven in external mode");

   property p_pullup;
      cs_s |=> pins.sck_pullup;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up off while deselected");
endmodule
`default_nettype wire

// ### astm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module astm_host_model (
   // Clock
   input wire logic ref_clk,
   // Device pins
   input wire astm_pkg::astm_pins_t pins,
   output var logic cs_n,
   output wire logic sck_in,
   output var logic sdi
);
   import astm_pkg::*;
   logic sck_drv = 1'b0;
   logic sck_val = 1'b0;
   logic sck_last = 1'b1;
   logic sdo_q = 1'b0;
   wire logic sdo_pin;
   initial begin
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // Undriven lines without pull-up wander
   assign sck_in = pins.sck_oe ? pins.sck_out : sck_drv ? sck_val : pins.sck_pullup ? 1'b1 : ~sck_last;
   assign sdo_pin = pins.sdo_oe ? pins.sdo_out : ~sdo_q;
   always @(posedge ref_clk) begin
      sck_last <= sck_in;
      sdo_q <= sdo_pin;
   end
   task automatic set_lines(input logic drv, input logic cs);
      sck_drv <= drv;
      sck_val <= 1'b0;
      cs_n <= cs;
   endtask
   task automatic wait_sck(input logic v, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(sck_in === v && sck_last !== v) && n < 3000);
   endtask
   task automatic ext_word(input logic [15:0] din, output logic [31:0] dout);
      dout = '0;
      // 80 ns link clock; data out read one cycle into the high phase
      for (int i = 0; i < 32; i++) begin
         sdi <= (i < 16) ? din[15 - i] : 1'b0;
         repeat (4) @(posedge ref_clk);
         sck_val <= 1'b1;
         @(posedge ref_clk);
         dout = {dout[30:0], sdo_pin};
         repeat (3) @(posedge ref_clk);
         sck_val <= 1'b0;
      end
      repeat (10) @(posedge ref_clk);
   endtask
   task automatic int_word(input logic [15:0] din, input int falls, output logic [31:0] dout, output int probe);
      int n;
      dout = '0;
      cs_n <= 1'b0;
      sdi <= din[15];
      wait_sck(1'b1, probe);
      for (int i = 0; i < 32; i++) begin
         if (i > 0) wait_sck(1'b1, n);
         // Level held just before the clock rose
         dout = {dout[30:0], sdo_q};
         if (i == 31) break;
         wait_sck(1'b0, n);
         if (i + 1 == falls) begin
            cs_n <= 1'b1;
            break;
         end
         sdi <= (i < 15) ? din[14 - i] : 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import astm_pkg::*;
   localparam int POR_P = 50;
   localparam int HALF_P = 10;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic ext_osc_sel = 1'b0;
   logic conv_done = 1'b0;
   logic [30:0] conv_result = '0;
   logic cs_n, sck_in, sdi, conv_start, converting;
   astm_pins_t pins;
   astm_sel_t sel;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   int n_start = 0;

   astm_serial_port #(.POR_CYCLES_P(POR_P), .SCK_HALF_P(HALF_P)) i_dut (.ref_clk(ref_clk), .reset(reset),
      .cs_n(cs_n), .sck_in(sck_in), .sdi(sdi), .ext_osc_sel(ext_osc_sel), .pins(pins), .conv_done(conv_done),
      .conv_result(conv_result), .conv_start(conv_start), .converting(converting), .sel(sel));
   astm_host_model i_host (.ref_clk(ref_clk), .pins(pins), .cs_n(cs_n), .sck_in(sck_in), .sdi(sdi));

   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (conv_start === 1'b1) n_start <= n_start + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset(input logic sck_low, input logic cs);
      i_host.set_lines(sck_low, cs);
      reset <= 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (POR_P / 2) @(posedge ref_clk);
      chk(pins.sck_pullup, 1);
      repeat (POR_P / 2 + 10) @(posedge ref_clk);
   endtask
   task automatic finish_conv(input logic [30:0] res);
      conv_result <= res;
      conv_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic t_ext();
      logic [31:0] w;
      int s0;
      s0 = n_start;
      do_reset(1'b1, 1'b0);
      chk(n_start - s0, 1);
      chk({pins.sck_oe, pins.sdo_oe, pins.sdo_out}, 3'b011);
      finish_conv(31'h1234_5678);
      repeat (2) @(posedge ref_clk);
      chk({pins.sdo_oe, pins.sdo_out}, 2'b10);
      i_host.ext_word(16'ha53c, w);
      chk(w, {1'b0, 31'h1234_5678});
      chk(n_start - s0, 2);
      chk({pins.sdo_out, sel}, {1'b1, 16'ha53c});
      $display("test ext done");
   endtask

   task automatic t_int();
      logic [31:0] w;
      int p, s0, e;
      do_reset(1'b0, 1'b1);
      chk({pins.sdo_oe, pins.sck_pullup}, 2'b01);
      finish_conv(31'h0f0f_5a5a);
      s0 = n_start;
      i_host.set_lines(1'b0, 1'b0);
      repeat (20) @(posedge ref_clk);
      chk({pins.sck_oe, pins.sck_out, pins.sdo_oe, pins.sdo_out}, 4'b1010);
      i_host.set_lines(1'b0, 1'b1);
      repeat (20) @(posedge ref_clk);
      chk(n_start - s0, 0);
      chk(pins.sdo_oe, 0);
      for (int k = 0; k < 2; k++) begin
         ext_osc_sel <= k[0];
         repeat (4) @(posedge ref_clk);
         e = (k == 0) ? PROBE_CYCLES : EXT_OSC_PERIODS_X10 * (CLK_HZ / 10) / EXT_OSC_HZ;
         i_host.int_word(16'h5a00 + 16'(k), 99, w, p);
         chk(p >= e - 2 && p <= e + 10, 1);
         chk(w, {1'b0, (k == 0) ? 31'h0f0f_5a5a : 31'h3c3c_0101});
         repeat (6) @(posedge ref_clk);
         chk({pins.sck_out, pins.sdo_out, sel}, {2'b11, 16'h5a00 + 16'(k)});
         i_host.set_lines(1'b0, 1'b1);
         finish_conv(31'h3c3c_0101);
      end
      $display("test int done");
   endtask

   task automatic t_abort();
      logic [31:0] w;
      logic [15:0] prev, din;
      int p, s0;
      int falls[3] = '{3, 10, 20};
      for (int k = 0; k < 3; k++) begin
         prev = sel;
         din = 16'h9966 + 16'(k) * 16'h1111;
         finish_conv(31'h0000_0001);
         s0 = n_start;
         i_host.int_word(din, falls[k], w, p);
         repeat (8) @(posedge ref_clk);
         chk(n_start - s0, 1);
         chk(sel, (k == 0) ? prev : (k == 1) ? {din[15:8], prev[7:0]} : din);
      end
      $display("test abort done");
   endtask

   task automatic t_cont();
      logic [31:0] w;
      int p, s0;
      do_reset(1'b0, 1'b0);
      chk({pins.sck_oe, pins.sck_out, pins.sdo_out}, 3'b111);
      finish_conv(31'h2bad_cafe);
      chk({pins.sck_out, pins.sdo_out}, 2'b00);
      s0 = n_start;
      i_host.int_word(16'h7e81, 99, w, p);
      chk(p + 2 >= HALF_P - 1 && p + 2 <= HALF_P + 4, 1);
      chk(w, {1'b0, 31'h2bad_cafe});
      repeat (6) @(posedge ref_clk);
      chk(n_start - s0, 1);
      chk({pins.sck_out, pins.sdo_out, sel}, {2'b11, 16'h7e81});
      $display("test cont done");
   endtask

   initial begin
      t_ext();
      t_int();
      t_abort();
      t_cont();
      give_verdict();
   end
endmodule
`default_nettype wire
